// >>> logic/vac_consts.svh
// Purpose: offsets, field positions, reset values and codes of the VCO autocal register bank
// Assumes: 8-bit registers, 15-bit serial port address
// Notes: definitions only
`ifndef VAC_CONSTS_SVH
`define VAC_CONSTS_SVH

`define VAC_ADDR_W 15
`define VAC_DATA_W 8
`define VAC_FRAME_BITS 5'h18
`define VAC_ADDR_END 5'h10

`define VAC_OFS_LEVEL_CTRL 15'h002C
`define VAC_OFS_BAND_DIV 15'h0030
`define VAC_OFS_TIMEOUT_LOW 15'h0031
`define VAC_OFS_CONV_CTRL 15'h0032
`define VAC_OFS_LOCK_RB 15'h0033
`define VAC_OFS_TEST_MODE 15'h0034
`define VAC_OFS_CONV_DIV 15'h0035
`define VAC_OFS_PUMP_TRIM 15'h0036
`define VAC_OFS_BAND_OVR 15'h0037
`define VAC_OFS_CORE_OVR 15'h0038
`define VAC_OFS_RESULT_LO 15'h006E
`define VAC_OFS_RESULT_HI 15'h006F
`define VAC_OFS_CLK_CTRL 15'h0073

`define VAC_REG_RESET 8'h00
`define VAC_RESULT_RESET 16'h0000
`define VAC_CHECKERBOARD 16'hAA55

`define VAC_BIT_LEVEL_OFF 0
`define VAC_BIT_MUX_SEL 7
`define VAC_BIT_FAST 5
`define VAC_BIT_CONT 4
`define VAC_BIT_CONVERT 3
`define VAC_BIT_CONV_EN 2
`define VAC_BIT_CONV_CLK_OFF 2
`define VAC_LSB_TIMEOUT_HI 0
`define VAC_MSB_TIMEOUT_HI 1
`define VAC_LSB_LOCK_WAIT 0
`define VAC_MSB_LOCK_WAIT 4
`define VAC_LSB_RB_SRC 5
`define VAC_MSB_RB_SRC 7
`define VAC_LSB_TEST_SEL 5
`define VAC_MSB_TEST_SEL 7
`define VAC_LSB_LEVEL_WAIT 0
`define VAC_MSB_LEVEL_WAIT 4
`define VAC_LSB_CORE 4
`define VAC_MSB_CORE 7

`define VAC_CONV_DIV_MUL 10'h004
`define VAC_CONV_DIV_ADD 10'h002

`endif

// >>> logic/vac_pkg.sv
// Purpose: shared types of the VCO autocal register bank
// Assumes: codes as held by the register fields
// Notes: no constants here, those live in vac_consts.svh
package vac_pkg;

    typedef enum logic [2:0] {
        VAC_MODE_NORMAL = 3'h0,
        VAC_MODE_CORE_BAND = 3'h2,
        VAC_MODE_VOLTAGE = 3'h4
    } vac_test_mode_t;

    typedef enum logic [2:0] {
        VAC_RB_CHECKER = 3'h0,
        VAC_RB_CORE_BAND = 3'h1,
        VAC_RB_TEMP = 3'h5
    } vac_rb_src_t;

    typedef enum logic [1:0] {
        VAC_SP_IDLE = 2'h0,
        VAC_SP_ADDR = 2'h1,
        VAC_SP_DATA = 2'h2
    } vac_sp_state_t;

endpackage

// >>> logic/vac_reg_if.sv
// Purpose: carrier between the serial port and the register bank
// Assumes: one core clock domain
// Notes: wr_en is a one-cycle pulse, rdata is combinational from addr
`timescale 1ns/1ps
`include "vac_consts.svh"
interface vac_reg_if;
    logic wr_en;
    logic [`VAC_ADDR_W-1:0] addr;
    logic [`VAC_DATA_W-1:0] wdata;
    logic [`VAC_DATA_W-1:0] rdata;

    modport port (output wr_en, output addr, output wdata, input rdata);
    modport bank (input wr_en, input addr, input wdata, output rdata);
endinterface

// >>> logic/vac_serial_port.sv
// Purpose: serial programming port slave, 24-bit frames, MSB first
// Assumes: sclk, cs and sdi synchronous to core_clk, each sclk phase >= 2 core cycles
// Notes: frame = read flag, 15-bit address, 8-bit data
`timescale 1ns/1ps
`include "vac_consts.svh"
module vac_serial_port (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_sdi_i,
    output logic spi_sdo_o,
    output logic spi_sdo_oe_o,
    vac_reg_if.port regs
);
    logic sclk_q;
    logic [4:0] bit_cnt;
    logic [22:0] rx_shift;
    logic rd_flag;
    logic [7:0] tx_shift;
    logic load_pend;
    logic fresh;
    logic wr_pulse;
    vac_pkg::vac_sp_state_t state;

    wire sclk_rise = ~spi_cs_n_i & spi_sclk_i & ~sclk_q;
    wire sclk_fall = ~spi_cs_n_i & ~spi_sclk_i & sclk_q;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= spi_sclk_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i || spi_cs_n_i) begin
            bit_cnt <= 5'h00;
            rx_shift <= 23'h000000;
            rd_flag <= 1'b0;
            state <= vac_pkg::VAC_SP_IDLE;
        end else if (sclk_rise && bit_cnt != `VAC_FRAME_BITS) begin
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'h00) begin
                rd_flag <= spi_sdi_i;
                state <= vac_pkg::VAC_SP_ADDR;
            end else begin
                rx_shift <= {rx_shift[21:0], spi_sdi_i};
            end
            if (bit_cnt + 5'h01 == `VAC_ADDR_END) begin
                state <= vac_pkg::VAC_SP_DATA;
            end
        end
    end

    // write fires once, one core cycle after the rising edge that completes the frame is detected
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            wr_pulse <= 1'b0;
        end else begin
            wr_pulse <= sclk_rise && !rd_flag && bit_cnt == `VAC_FRAME_BITS - 5'h01;
        end
    end

    // the first falling edge after load keeps bit 7 on the line
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i || spi_cs_n_i) begin
            tx_shift <= `VAC_REG_RESET;
            load_pend <= 1'b0;
            fresh <= 1'b0;
        end else if (sclk_rise && bit_cnt + 5'h01 == `VAC_ADDR_END) begin
            load_pend <= 1'b1;
        end else if (load_pend) begin
            load_pend <= 1'b0;
            tx_shift <= regs.rdata;
            fresh <= 1'b1;
        end else if (sclk_fall && state == vac_pkg::VAC_SP_DATA) begin
            if (fresh) begin
                fresh <= 1'b0;
            end else begin
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end
    end

    assign regs.wr_en = wr_pulse;
    // a read looks its register up right after the address, before the data bits push it up
    assign regs.addr = wr_pulse ? rx_shift[22:8] : rx_shift[14:0];
    assign regs.wdata = rx_shift[7:0];
    assign spi_sdo_o = tx_shift[7];
    assign spi_sdo_oe_o = ~spi_cs_n_i & rd_flag & (state == vac_pkg::VAC_SP_DATA);
endmodule // vac_serial_port

// >>> logic/vac_autocal_bank.sv
// Purpose: VCO autocalibration control register bank with divided calibration and converter ticks
// Assumes: pfd_clk_i sampled as an ordinary input, well below half the core clock rate
// Notes: registers reached only through the serial programming port
// Functional notes
// RULE1: level-control bit 0 drives level control off; software keeps it at one.
// RULE2: band calibration tick comes every divider-value phase detector cycles.
// RULE3: ten-bit timeout joins the timeout register with converter control bits 1:0.
// RULE4: converter control bit 7 picks temperature voltage or scaled tuning voltage.
// RULE5: converter bits enable, convert request, continuous and fast modes.
// RULE6: lock-timeout bits 4:0 give the five-bit lock wait limit.
// RULE7: readback source 000 checkerboard, 001 core and band, 101 temperature reading.
// RULE8: test-mode bits 7:5 select normal, core/band override or voltage override.
// RULE9: software keeps level-control wait limit field at zero.
// RULE10: converter tick every four times divider plus two detector cycles.
// RULE11: band override register drives VCO band when calibration is bypassed.
// RULE12: core override bits 7:4 drive VCO core when bypassed; low bits reserved.
// RULE13: every register resets to 0x00, reserved bits too.
// RULE14: converter enable overrides the converter clock-disable bit.
// RULE15: selected readback value appears in two read-only eight-bit result registers.
// RULE16: overrides apply only in core and band override mode.
`timescale 1ns/1ps
`include "vac_consts.svh"
module vac_autocal_bank (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_sdi_i,
    output logic spi_sdo_o,
    output logic spi_sdo_oe_o,
    input wire logic pfd_clk_i,
    input wire logic [3:0] auto_core_i,
    input wire logic [7:0] auto_band_i,
    input wire logic [7:0] temp_reading_i,
    output logic level_ctrl_off_o,
    output logic band_cal_tick_o,
    output logic [9:0] cal_timeout_o,
    output logic conv_input_tuning_o,
    output logic conv_enable_o,
    output logic conv_request_o,
    output logic converter_continuous_mode_o,
    output logic converter_fast_mode_o,
    output logic conv_tick_o,
    output logic conv_start_o,
    output logic [4:0] lock_wait_limit_o,
    output logic [2:0] cal_machine_test_select_o,
    output logic voltage_override_o,
    output logic [4:0] level_ctrl_wait_limit_o,
    output logic [7:0] pump_current_trim_value_o,
    output logic [3:0] vco_core_o,
    output logic [7:0] vco_band_o
);
    vac_reg_if regs ();

    logic [7:0] level_control_disable;
    logic [7:0] band_cal_divider;
    logic [7:0] cal_timeout_low;
    logic [7:0] converter_control;
    logic [7:0] lock_timeout_readback_sel;
    logic [7:0] cal_test_mode;
    logic [7:0] converter_clock_divider;
    logic [7:0] pump_current_trim;
    logic [7:0] band_override;
    logic [7:0] core_override;
    logic [7:0] converter_clock_ctrl;
    logic [15:0] cal_result_value;
    logic [15:0] next_cal_result_value;
    logic pfd_q;
    logic [7:0] band_cnt;
    logic [9:0] conv_cnt;
    logic [9:0] conv_period;
    logic conv_clk_run;
    logic [7:0] next_rdata;

    vac_serial_port u_port (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .spi_cs_n_i(spi_cs_n_i),
        .spi_sclk_i(spi_sclk_i),
        .spi_sdi_i(spi_sdi_i),
        .spi_sdo_o(spi_sdo_o),
        .spi_sdo_oe_o(spi_sdo_oe_o),
        .regs(regs)
    );

    // a write lands in the register whose offset matches
    function automatic logic hit(input logic [14:0] ofs);
        return regs.wr_en && regs.addr == ofs;
    endfunction

    // terminal count of a divider; a zero period never fires
    // a count already past a newly shortened period wraps at once instead of running round
    function automatic logic last_count(input logic [9:0] cnt, input logic [9:0] period);
        return period != 10'h000 && cnt >= period - 10'h001;
    endfunction

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            level_control_disable <= `VAC_REG_RESET; // RULE13
            band_cal_divider <= `VAC_REG_RESET;
            cal_timeout_low <= `VAC_REG_RESET;
            converter_control <= `VAC_REG_RESET;
            lock_timeout_readback_sel <= `VAC_REG_RESET;
            cal_test_mode <= `VAC_REG_RESET;
            converter_clock_divider <= `VAC_REG_RESET;
            pump_current_trim <= `VAC_REG_RESET;
            band_override <= `VAC_REG_RESET;
            core_override <= `VAC_REG_RESET;
            converter_clock_ctrl <= `VAC_REG_RESET;
        end else begin
            if (hit(`VAC_OFS_LEVEL_CTRL)) begin
                level_control_disable <= regs.wdata;
            end
            if (hit(`VAC_OFS_BAND_DIV)) begin
                band_cal_divider <= regs.wdata;
            end
            if (hit(`VAC_OFS_TIMEOUT_LOW)) begin
                cal_timeout_low <= regs.wdata;
            end
            if (hit(`VAC_OFS_CONV_CTRL)) begin
                converter_control <= regs.wdata;
            end
            if (hit(`VAC_OFS_LOCK_RB)) begin
                lock_timeout_readback_sel <= regs.wdata;
            end
            if (hit(`VAC_OFS_TEST_MODE)) begin
                cal_test_mode <= regs.wdata;
            end
            if (hit(`VAC_OFS_CONV_DIV)) begin
                converter_clock_divider <= regs.wdata;
            end
            if (hit(`VAC_OFS_PUMP_TRIM)) begin
                pump_current_trim <= regs.wdata;
            end
            if (hit(`VAC_OFS_BAND_OVR)) begin
                band_override <= regs.wdata;
            end
            // reserved low bits are stored as written; software writes zero there
            if (hit(`VAC_OFS_CORE_OVR)) begin
                core_override <= regs.wdata;
            end
            if (hit(`VAC_OFS_CLK_CTRL)) begin
                converter_clock_ctrl <= regs.wdata;
            end
        end
    end

    // readback result is registered every cycle, one cycle behind the selected source
    always_comb begin
        next_cal_result_value = `VAC_RESULT_RESET;
        unique case (lock_timeout_readback_sel[`VAC_MSB_RB_SRC:`VAC_LSB_RB_SRC])
            vac_pkg::VAC_RB_CHECKER: next_cal_result_value = `VAC_CHECKERBOARD; // RULE7
            vac_pkg::VAC_RB_CORE_BAND: next_cal_result_value = {4'h0, vco_core_o, vco_band_o}; // RULE7
            vac_pkg::VAC_RB_TEMP: next_cal_result_value = {8'h00, temp_reading_i}; // RULE7
            default: next_cal_result_value = `VAC_RESULT_RESET;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            cal_result_value <= `VAC_RESULT_RESET;
        end else begin
            cal_result_value <= next_cal_result_value; // RULE15
        end
    end

    always_comb begin
        next_rdata = `VAC_REG_RESET;
        unique case (regs.addr)
            `VAC_OFS_LEVEL_CTRL: next_rdata = level_control_disable;
            `VAC_OFS_BAND_DIV: next_rdata = band_cal_divider;
            `VAC_OFS_TIMEOUT_LOW: next_rdata = cal_timeout_low;
            `VAC_OFS_CONV_CTRL: next_rdata = converter_control;
            `VAC_OFS_LOCK_RB: next_rdata = lock_timeout_readback_sel;
            `VAC_OFS_TEST_MODE: next_rdata = cal_test_mode;
            `VAC_OFS_CONV_DIV: next_rdata = converter_clock_divider;
            `VAC_OFS_PUMP_TRIM: next_rdata = pump_current_trim;
            `VAC_OFS_BAND_OVR: next_rdata = band_override;
            `VAC_OFS_CORE_OVR: next_rdata = core_override;
            `VAC_OFS_CLK_CTRL: next_rdata = converter_clock_ctrl;
            `VAC_OFS_RESULT_LO: next_rdata = cal_result_value[7:0]; // RULE15
            `VAC_OFS_RESULT_HI: next_rdata = cal_result_value[15:8]; // RULE15
            default: next_rdata = `VAC_REG_RESET;
        endcase
    end

    assign regs.rdata = next_rdata;

    // phase detector edges are counted, not used as a clock, to stay in one domain
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            pfd_q <= 1'b0;
        end else begin
            pfd_q <= pfd_clk_i;
        end
    end

    wire pfd_rise = pfd_clk_i & ~pfd_q;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            band_cnt <= 8'h00;
            band_cal_tick_o <= 1'b0;
        end else begin
            band_cal_tick_o <= 1'b0;
            if (band_cal_divider == 8'h00) begin
                band_cnt <= 8'h00;
            end else if (pfd_rise) begin
                if (last_count({2'h0, band_cnt}, {2'h0, band_cal_divider})) begin
                    band_cnt <= 8'h00;
                    band_cal_tick_o <= 1'b1; // RULE2
                end else begin
                    band_cnt <= band_cnt + 8'h01;
                end
            end
        end
    end

    assign conv_period = {2'h0, converter_clock_divider} * `VAC_CONV_DIV_MUL + `VAC_CONV_DIV_ADD; // RULE10
    assign conv_clk_run = converter_control[`VAC_BIT_CONV_EN]
        | ~converter_clock_ctrl[`VAC_BIT_CONV_CLK_OFF]; // RULE14

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            conv_cnt <= 10'h000;
            conv_tick_o <= 1'b0;
        end else begin
            conv_tick_o <= 1'b0;
            if (!conv_clk_run) begin
                conv_cnt <= 10'h000;
            end else if (pfd_rise) begin
                if (last_count(conv_cnt, conv_period)) begin
                    conv_cnt <= 10'h000;
                    conv_tick_o <= 1'b1; // RULE10
                end else begin
                    conv_cnt <= conv_cnt + 10'h001;
                end
            end
        end
    end

    // a conversion starts one core cycle after a converter tick seen while enabled and requested or continuous
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            conv_start_o <= 1'b0;
        end else begin
            conv_start_o <= conv_tick_o && converter_control[`VAC_BIT_CONV_EN]
                && (converter_control[`VAC_BIT_CONVERT] || converter_control[`VAC_BIT_CONT]); // RULE5
        end
    end

    assign level_ctrl_off_o = level_control_disable[`VAC_BIT_LEVEL_OFF]; // RULE1
    assign cal_timeout_o = {converter_control[`VAC_MSB_TIMEOUT_HI:`VAC_LSB_TIMEOUT_HI],
        cal_timeout_low}; // RULE3
    assign conv_input_tuning_o = converter_control[`VAC_BIT_MUX_SEL]; // RULE4
    assign conv_enable_o = converter_control[`VAC_BIT_CONV_EN]; // RULE5
    assign conv_request_o = converter_control[`VAC_BIT_CONVERT]; // RULE5
    assign converter_continuous_mode_o = converter_control[`VAC_BIT_CONT]; // RULE5
    assign converter_fast_mode_o = converter_control[`VAC_BIT_FAST]; // RULE5
    assign lock_wait_limit_o = lock_timeout_readback_sel[`VAC_MSB_LOCK_WAIT:`VAC_LSB_LOCK_WAIT]; // RULE6
    assign cal_machine_test_select_o = cal_test_mode[`VAC_MSB_TEST_SEL:`VAC_LSB_TEST_SEL]; // RULE8
    assign voltage_override_o = cal_machine_test_select_o == vac_pkg::VAC_MODE_VOLTAGE; // RULE8
    // passed through as stored; a nonzero value is a software fault
    assign level_ctrl_wait_limit_o = cal_test_mode[`VAC_MSB_LEVEL_WAIT:`VAC_LSB_LEVEL_WAIT];
    assign pump_current_trim_value_o = pump_current_trim;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            vco_core_o <= 4'h0;
            vco_band_o <= 8'h00;
        end else if (cal_machine_test_select_o == vac_pkg::VAC_MODE_CORE_BAND) begin // RULE16
            vco_core_o <= core_override[`VAC_MSB_CORE:`VAC_LSB_CORE]; // RULE12
            vco_band_o <= band_override; // RULE11
        end else begin
            vco_core_o <= auto_core_i;
            vco_band_o <= auto_band_i;
        end
    end
endmodule // vac_autocal_bank

// >>> dv/vac_autocal_bank_chk.sv
// Purpose: concurrent checks on the autocal register bank ports
// Assumes: pfd rises at least two core cycles apart
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
module vac_autocal_bank_chk (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sdo_oe_o,
    input wire logic [3:0] auto_core_i,
    input wire logic [7:0] auto_band_i,
    input wire logic level_ctrl_off_o,
    input wire logic band_cal_tick_o,
    input wire logic [9:0] cal_timeout_o,
    input wire logic conv_enable_o,
    input wire logic conv_request_o,
    input wire logic converter_continuous_mode_o,
    input wire logic conv_tick_o,
    input wire logic conv_start_o,
    input wire logic [4:0] lock_wait_limit_o,
    input wire logic [2:0] cal_machine_test_select_o,
    input wire logic voltage_override_o,
    input wire logic [3:0] vco_core_o,
    input wire logic [7:0] vco_band_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_tick_armed;
        conv_tick_o && conv_enable_o && conv_request_o;
    endsequence
    // writes land while select is still low, so a quiet port means frozen registers
    sequence s_port_idle;
        spi_cs_n_i [*4];
    endsequence

    a_reset_zero: assert property (
        $rose(nrst_i) |-> cal_timeout_o == 10'h000 && lock_wait_limit_o == 5'h00 && vco_band_o == 8'h00)
        else $error("outputs not cleared by reset");
    a_auto_follow: assert property (
        cal_machine_test_select_o != 3'h2 |=> vco_core_o == $past(auto_core_i) && vco_band_o == $past(auto_band_i))
        else $error("vco selection not taken from calibration");
    a_volt_flag: assert property (
        voltage_override_o == (cal_machine_test_select_o == 3'h4))
        else $error("voltage override flag wrong");
    a_start_cause: assert property (
        conv_start_o |-> $past(conv_tick_o && conv_enable_o && (conv_request_o || converter_continuous_mode_o)))
        else $error("conversion start without cause");
    a_start_follow: assert property (
        s_tick_armed |=> conv_start_o)
        else $error("requested conversion did not start");
    a_band_pulse: assert property (
        band_cal_tick_o |=> !band_cal_tick_o)
        else $error("band tick longer than one cycle");
    a_conv_space: assert property (
        conv_tick_o |=> !conv_tick_o [*3])
        else $error("converter ticks too close");
    a_regs_hold: assert property (
        s_port_idle |-> $stable(cal_timeout_o) && $stable(level_ctrl_off_o) && $stable(cal_machine_test_select_o))
        else $error("register changed without a frame");
    a_sdo_quiet: assert property (
        spi_cs_n_i |-> !spi_sdo_oe_o)
        else $error("serial output driven while deselected");
endmodule // vac_autocal_bank_chk

bind vac_autocal_bank vac_autocal_bank_chk chk (.core_clk_i, .nrst_i, .spi_cs_n_i, .spi_sdo_oe_o, .auto_core_i,
    .auto_band_i, .level_ctrl_off_o, .band_cal_tick_o, .cal_timeout_o, .conv_enable_o, .conv_request_o,
    .converter_continuous_mode_o, .conv_tick_o, .conv_start_o, .lock_wait_limit_o, .cal_machine_test_select_o,
    .voltage_override_o, .vco_core_o, .vco_band_o);

// >>> dv/testbench.sv
// Purpose: self-checking bench for the autocal register bank
// Assumes: frames of read flag, address, data, msb first, three core cycles per sclk phase
// Notes: pfd clock free runs at six core cycles per period
`timescale 1ns/1ps
`include "vac_consts.svh"
module testbench;
    logic core_clk_i = 1'b0, nrst_i = 1'b0, spi_cs_n_i = 1'b1, spi_sclk_i = 1'b0, spi_sdi_i = 1'b0;
    logic pfd_clk_i = 1'b0;
    logic [3:0] auto_core_i = 4'h9;
    logic [7:0] auto_band_i = 8'h3C, temp_reading_i = 8'h7E;
    logic spi_sdo_o, spi_sdo_oe_o, level_ctrl_off_o, band_cal_tick_o, conv_input_tuning_o, conv_enable_o;
    logic conv_request_o, converter_continuous_mode_o, converter_fast_mode_o, conv_tick_o, conv_start_o;
    logic voltage_override_o;
    logic [9:0] cal_timeout_o;
    logic [4:0] lock_wait_limit_o, level_ctrl_wait_limit_o;
    logic [2:0] cal_machine_test_select_o;
    logic [7:0] pump_current_trim_value_o, vco_band_o, q;
    logic [3:0] vco_core_o;
    int errors = 0, checks_done = 0, gap;
    logic [14:0] ofs [10] = '{`VAC_OFS_LEVEL_CTRL, `VAC_OFS_BAND_DIV, `VAC_OFS_TIMEOUT_LOW, `VAC_OFS_CONV_CTRL,
        `VAC_OFS_LOCK_RB, `VAC_OFS_TEST_MODE, `VAC_OFS_CONV_DIV, `VAC_OFS_PUMP_TRIM, `VAC_OFS_BAND_OVR,
        `VAC_OFS_CORE_OVR};
    // level wait field kept at zero, reserved core bits set to prove they are stored
    logic [7:0] pat [10] = '{8'h01, 8'h03, 8'hA5, 8'hBE, 8'h31, 8'h80, 8'h02, 8'h30, 8'hC3, 8'h5A};
    wire [4:0] conv_bits = {conv_input_tuning_o, converter_fast_mode_o, converter_continuous_mode_o,
        conv_request_o, conv_enable_o};

    vac_autocal_bank dut (.core_clk_i, .nrst_i, .spi_cs_n_i, .spi_sclk_i, .spi_sdi_i, .spi_sdo_o, .spi_sdo_oe_o,
        .pfd_clk_i, .auto_core_i, .auto_band_i, .temp_reading_i, .level_ctrl_off_o, .band_cal_tick_o,
        .cal_timeout_o, .conv_input_tuning_o, .conv_enable_o, .conv_request_o, .converter_continuous_mode_o,
        .converter_fast_mode_o, .conv_tick_o, .conv_start_o, .lock_wait_limit_o, .cal_machine_test_select_o,
        .voltage_override_o, .level_ctrl_wait_limit_o, .pump_current_trim_value_o, .vco_core_o, .vco_band_o);

    always #10 core_clk_i = ~core_clk_i;
    // pfd edges land 1 ns after a core edge so sampling never races
    initial begin
        #11;
        forever #60 pfd_clk_i = ~pfd_clk_i;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] d, input int nb);
        logic [23:0] w;
        w = {rd, a, d};
        q = 8'h00;
        spi_cs_n_i = 1'b0;
        for (int i = 0; i < nb; i++) begin
            spi_sdi_i = w[23-i];
            cyc(3);
            if (i > 15 && rd) begin
                q = {q[6:0], spi_sdo_o};
                cmp({15'h0000, spi_sdo_oe_o}, 16'h0001);
            end
            spi_sclk_i = 1'b1;
            cyc(3);
            spi_sclk_i = 1'b0;
        end
        spi_cs_n_i = 1'b1;
        cyc(4);
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        frame(1'b0, a, d, 24);
    endtask
    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        frame(1'b1, a, 8'h00, 24);
        cmp({8'h00, q}, {8'h00, e});
    endtask
    task automatic gap_of(input bit conv, output int n);
        int first;
        first = -1;
        n = 0;
        for (int c = 0; c < 600 && n == 0; c++) begin
            if ((conv ? conv_tick_o : band_cal_tick_o) === 1'b1) begin
                if (first < 0) first = c;
                else n = c - first;
            end
            cyc(1);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge core_clk_i);
        errors++;
        close_out();
    end

    initial begin
        cyc(8);
        nrst_i = 1'b1;
        cyc(1);
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        rd(`VAC_OFS_RESULT_LO, 8'h55);
        rd(`VAC_OFS_RESULT_HI, 8'hAA);
        rd(15'h0050, 8'h00);
        $display("test reset values done");
        foreach (ofs[i]) wr(ofs[i], pat[i]);
        foreach (ofs[i]) rd(ofs[i], pat[i]);
        cmp({15'h0000, level_ctrl_off_o}, 16'h0001);
        cmp({6'h00, cal_timeout_o}, 16'h02A5);
        cmp({11'h000, conv_bits}, 16'h001F);
        cmp({2'h0, lock_wait_limit_o, cal_machine_test_select_o, voltage_override_o, level_ctrl_wait_limit_o},
            16'h2320);
        cmp({8'h00, pump_current_trim_value_o}, 16'h0030);
        frame(1'b0, `VAC_OFS_LEVEL_CTRL, 8'h00, 20);
        rd(`VAC_OFS_LEVEL_CTRL, 8'h01);
        wr(15'h0050, 8'hFF);
        rd(15'h0050, 8'h00);
        for (int b = 2; b < 8; b++) begin
            if (b != 6) begin
                wr(`VAC_OFS_CONV_CTRL, 8'h01 << b);
                cmp({11'h000, conv_bits}, {11'h000, b == 7, b == 5, b == 4, b == 3, b == 2});
            end
        end
        $display("test field mapping done");
        cmp({4'h0, vco_core_o, vco_band_o}, 16'h093C);
        wr(`VAC_OFS_RESULT_LO, 8'hFF);
        rd(`VAC_OFS_RESULT_LO, 8'h3C);
        rd(`VAC_OFS_RESULT_HI, 8'h09);
        wr(`VAC_OFS_TEST_MODE, {vac_pkg::VAC_MODE_CORE_BAND, 5'h00});
        cmp({4'h0, vco_core_o, vco_band_o}, 16'h05C3);
        rd(`VAC_OFS_RESULT_LO, 8'hC3);
        rd(`VAC_OFS_RESULT_HI, 8'h05);
        wr(`VAC_OFS_LOCK_RB, {vac_pkg::VAC_RB_TEMP, 5'h00});
        rd(`VAC_OFS_RESULT_LO, 8'h7E);
        rd(`VAC_OFS_RESULT_HI, 8'h00);
        wr(`VAC_OFS_LOCK_RB, 8'h40);
        rd(`VAC_OFS_RESULT_LO, 8'h00);
        $display("test readback and override done");
        gap_of(1'b0, gap);
        cmp(16'(gap), 16'h0012);
        wr(`VAC_OFS_CONV_CTRL, 8'h00);
        gap_of(1'b1, gap);
        cmp(16'(gap), 16'h003C);
        wr(`VAC_OFS_CLK_CTRL, 8'h04);
        gap_of(1'b1, gap);
        cmp(16'(gap), 16'h0000);
        wr(`VAC_OFS_CONV_CTRL, 8'h0C);
        gap_of(1'b1, gap);
        cmp(16'(gap), 16'h003C);
        wr(`VAC_OFS_CONV_DIV, 8'h00);
        gap_of(1'b1, gap);
        cmp(16'(gap), 16'h000C);
        wr(`VAC_OFS_BAND_DIV, 8'h00);
        gap_of(1'b0, gap);
        cmp(16'(gap), 16'h0000);
        $display("test dividers done");
        nrst_i = 1'b0;
        cyc(2);
        cmp({6'h00, cal_timeout_o}, 16'h0000);
        nrst_i = 1'b1;
        cyc(1);
        rd(`VAC_OFS_BAND_OVR, 8'h00);
        rd(`VAC_OFS_CLK_CTRL, 8'h00);
        $display("test second reset done");
        close_out();
    end
endmodule // testbench
